// ---- verilog/video_out_port.sv ----
// Video output port toward a frame grabber with a forwarded pixel clock.
`default_nettype none
module video_out_port
    import video_out_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] mode,
    input wire logic in_valid,
    output logic in_ready,
    input wire pix_word_t in_word,
    input wire logic trigger_input_pin,
    output logic camera_trigger,
    output logic pclk_out,
    output video_bus_t video_out
);
    // Words wait in a short buffer so a stall on the camera side loses nothing.
    // The forwarded clock is a divided copy of mclk, and the bus changes only
    // at its falling edge, so the grabber sees a settled word at every rise.
    typedef struct packed {
        pix_word_t [DEPTH-1:0] buf_q;
        logic [DEPTH-1:0] buf_v;
        logic [HALF_W-1:0] div_cnt;
        logic pclk;
        logic [1:0] mode_s1;
        logic [1:0] mode_s2;
        logic fr;
        logic ln;
        logic [BUS_BITS-1:0] dout;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic [1:0] mode_eff;
    logic [HALF_W-1:0] half;
    logic half_done;
    logic fall;
    logic pop;
    logic push;
    logic [DEPTH-1:0] v_after_pop;
    logic [DEPTH-1:0] pick;
    pix_word_t head;

    // Half period of the forwarded clock in mclk cycles for a mode.
    function automatic logic [HALF_W-1:0] half_for_mode(input logic [1:0] m);
        logic [HALF_W-1:0] h;
        h = HALF_W'(SINGLE_HALF_CYC);
        case (m)
            MODE_SINGLE10: begin
                h = HALF_W'(SINGLE_HALF_CYC);
            end
            MODE_SINGLE8: begin
                h = HALF_W'(SINGLE_HALF_CYC);
            end
            MODE_DUAL8: begin
                h = HALF_W'(DUAL_HALF_CYC);
            end
            default: begin
                h = HALF_W'(SINGLE_HALF_CYC);
            end
        endcase
        return h;
    endfunction

    // Only the three supported camera modes put pixels on the bus.
    function automatic logic mode_ok(input logic [1:0] m);
        logic ok;
        ok = 1'b0;
        case (m)
            MODE_SINGLE10: begin
                ok = 1'b1;
            end
            MODE_SINGLE8: begin
                ok = 1'b1;
            end
            MODE_DUAL8: begin
                ok = 1'b1;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // Places one word on the bus lines by mode.
    // mode picks bit placement
    function automatic logic [BUS_BITS-1:0] map_bus(input logic [1:0] m, input pix_word_t w);
        logic [BUS_BITS-1:0] b;
        b = '0;
        case (m)
            MODE_SINGLE10: begin
                b[PIX_BITS-1:0] = w.pix_a;
            end
            MODE_SINGLE8: begin
                b[BYTE_BITS-1:0] = w.pix_a[PIX_BITS-1 -: BYTE_BITS];
            end
            MODE_DUAL8: begin
                b[BYTE_BITS-1:0] = w.pix_a[PIX_BITS-1 -: BYTE_BITS];
                b[BUS_BITS-1:BYTE_BITS] = w.pix_b[PIX_BITS-1 -: BYTE_BITS];
            end
            default: begin
                b = '0;
            end
        endcase
        return b;
    endfunction

    assign camera_trigger = trigger_input_pin;

    // The mode comes from the camera side, so only the second stage is read.
    assign mode_eff = s_r.mode_s2;

    assign half = half_for_mode(mode_eff);
    assign half_done = (s_r.div_cnt == half - HALF_W'(1));
    assign fall = half_done && s_r.pclk;

    // The head of the buffer leaves at each falling edge of the forwarded clock.
    assign head = s_r.buf_q[0];
    assign pop = fall && s_r.buf_v[0];
    assign in_ready = !s_r.buf_v[DEPTH-1];
    assign push = in_valid && in_ready;
    assign v_after_pop = pop ? (s_r.buf_v >> 1) : s_r.buf_v;

    // One-hot choice of the lowest free entry once the head has left.
    generate
        for (genvar g = 0; g < DEPTH; g++) begin : g_pick
            if (g == 0) begin : g_head
                assign pick[g] = !v_after_pop[g];
            end else begin : g_tail
                assign pick[g] = !v_after_pop[g] && v_after_pop[g-1];
            end
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        s_nxt.mode_s1 = mode;
        s_nxt.mode_s2 = s_r.mode_s1;
        if (half_done) begin
            s_nxt.div_cnt = '0;
            s_nxt.pclk = !s_r.pclk;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + HALF_W'(1);
        end
        if (fall) begin
            if (s_r.buf_v[0] && mode_ok(mode_eff)) begin
                s_nxt.fr = head.frame;
                s_nxt.ln = head.frame & head.line;
                if (head.frame) begin
                    s_nxt.dout = map_bus(mode_eff, head);
                end else begin
                    s_nxt.dout = '0;
                end
            end else begin
                s_nxt.fr = 1'b0;
                s_nxt.ln = 1'b0;
                s_nxt.dout = '0;
            end
        end
        // Popping shifts every entry one place toward the head.
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_nxt.buf_q[i] = s_r.buf_q[i + 1];
                s_nxt.buf_v[i] = s_r.buf_v[i + 1];
            end
            s_nxt.buf_v[DEPTH-1] = 1'b0;
        end
        // A taken word goes to the lowest entry that is free after the pop.
        if (push) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (pick[i]) begin
                    s_nxt.buf_q[i] = in_word;
                    s_nxt.buf_v[i] = 1'b1;
                end
            end
        end
    end

    // Asynchronous clear returns every field, the mode stages included, to zero.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pclk_out = s_r.pclk;
    assign video_out.frame_active_flag = s_r.fr;
    assign video_out.line_active_flag = s_r.ln;
    assign video_out.dout = s_r.dout;
endmodule
`default_nettype wire

// ---- verilog/video_out_pkg.sv ----
// Package with the modes, carriers and timing constants of the video output port.
`default_nettype none
package video_out_pkg;
    localparam int PIX_BITS = 10;
    localparam int BUS_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int SINGLE_PCLK_MHZ = 42;
    localparam int DUAL_PCLK_MHZ = 21;
    localparam int MCLK_MHZ = 250;
    // Half periods of the forwarded clock, rounded down, in mclk cycles.
    localparam int SINGLE_HALF_CYC = MCLK_MHZ / (2 * SINGLE_PCLK_MHZ);
    localparam int DUAL_HALF_CYC = MCLK_MHZ / (2 * DUAL_PCLK_MHZ);
    localparam int SINGLE_LINE_CYC = 1008;
    localparam int DUAL_LINE_CYC = 504;
    localparam int HALF_W = 4;

    typedef enum logic [1:0] {
        MODE_SINGLE10 = 2'h0,
        MODE_SINGLE8 = 2'h1,
        MODE_DUAL8 = 2'h2
    } out_mode_t;

    // One pixel word from the camera side.
    typedef struct packed {
        logic frame;
        logic line;
        logic [PIX_BITS-1:0] pix_a;
        logic [PIX_BITS-1:0] pix_b;
    } pix_word_t;

    // What is presented to the frame grabber.
    typedef struct packed {
        logic frame_active_flag;
        logic line_active_flag;
        logic [BUS_BITS-1:0] dout;
    } video_bus_t;
endpackage
`default_nettype wire

// ---- verif/video_out_port_monitor.sv ----
// Checker for the video output port.
`default_nettype none
module video_out_port_monitor import video_out_pkg::*; (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] mode,
    input wire logic trigger_input_pin,
    input wire logic camera_trigger,
    input wire logic pclk_out,
    input wire video_bus_t video_out
);
    wire fa = video_out.frame_active_flag;
    wire la = video_out.line_active_flag;
    wire [15:0] d = video_out.dout;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_hi4; pclk_out [*4] ##1 !pclk_out; endsequence
    a_trig_wire: assert property (camera_trigger == trigger_input_pin) else $error("f");
    a_line_frame: assert property (la |-> fa) else $error("f");
    a_data_stable: assert property ($rose(pclk_out) |-> $stable(video_out)) else $error("f");
    a_single_rate: assert property ($rose(pclk_out) && mode != 2 |=> pclk_out ##1 !pclk_out)
        else $error("f");
    a_dual_rate: assert property ($rose(pclk_out) && mode == 2 |=> s_hi4) else $error("f");
    a_map_s10: assert property (mode == 0 |-> d[15:10] == 0) else $error("f");
    a_map_s8: assert property (mode == 1 |-> d[15:8] == 0) else $error("f");
    a_idle_zero: assert property (!fa |-> d == 0) else $error("f");
endmodule
bind video_out_port video_out_port_monitor video_out_port_monitor_i (.mclk, .rst_b, .mode,
    .trigger_input_pin, .camera_trigger, .pclk_out, .video_out);
`default_nettype wire

// ---- verif/grabber_model.sv ----
// Frame grabber model that captures valid words and drives the trigger.
`default_nettype none
module grabber_model import video_out_pkg::*; (
    input wire logic mclk,
    input wire logic pclk_out,
    input wire video_bus_t video_out,
    output logic trig = 0,
    output int cnt = 0,
    output logic [15:0] cap [16]
);
    logic p = 0;
    logic [7:0] t = 0;
    always @(negedge mclk) begin
        t <= t + 8'h1;
        trig <= t[3] ^ t[6];
    end
    always @(posedge mclk) begin
        p <= pclk_out;
        if (pclk_out && !p && video_out.frame_active_flag && video_out.line_active_flag) begin
            cap[cnt[3:0]] <= video_out.dout;
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ---- verif/video_out_port_tb_top.sv ----
// Testbench for the video output port.
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module video_out_port_tb_top import video_out_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_b = 0, in_valid = 0, in_ready, trig, ctrig, pclk, st;
    logic [1:0] mode = 0;
    pix_word_t in_word = '0;
    video_bus_t vo;
    int fail_count = 0, total_checks = 0, cnt;
    logic [15:0] cap [16];
    always #2 mclk = ~mclk;
    video_out_port video_out_port_i (.mclk, .rst_b, .mode, .in_valid, .in_ready, .in_word,
        .trigger_input_pin(trig), .camera_trigger(ctrig), .pclk_out(pclk), .video_out(vo));
    grabber_model grabber_model_i (.mclk, .pclk_out(pclk), .video_out(vo), .trig, .cnt, .cap);
    task report_and_stop;
        $display("checks %0d failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task put(input logic l, input logic [9:0] a, input logic [9:0] b);
        int n;
        n = 0;
        in_valid = 1;
        in_word = '{1'b1, l, a, b};
        while (!in_ready && n < 99) begin @(negedge mclk); n++; st = 1; end
        if (n > 98) begin fail_count++; report_and_stop; end
        @(negedge mclk);
    endtask
    function automatic logic [15:0] map(input logic [1:0] m, input logic [9:0] a, b);
        if (m == 0) return {6'h0, a};
        if (m == 1) return {8'h0, a[9:2]};
        return {b[9:2], a[9:2]};
    endfunction
    task run_mode(input logic [1:0] m);
        int b, n, len;
        rst_b = 0;
        mode = m;
        repeat (3) @(negedge mclk);
        rst_b = 1;
        st = 0;
        b = cnt;
        put(0, 10'h3ff, 10'h3ff);
        for (int i = 0; i < 4; i++) put(1, 10'(10'h2a5 + i * 68), 10'(10'h15b + i));
        in_valid = 0;
        n = 0;
        while (cnt < b + 4 && n < 999) begin @(negedge mclk); n++; end
        if (n > 998) begin fail_count++; report_and_stop; end
        for (int i = 0; i < 4; i++)
            `CHK(cap[4'(b + i)], map(m, 10'(10'h2a5 + i * 68), 10'(10'h15b + i)))
        `CHK(st, 1'b1)
        repeat (12) @(negedge mclk);
        `CHK(vo, 18'h0)
        `CHK(ctrig, trig)
        len = (m == MODE_DUAL8) ? DUAL_LINE_CYC : SINGLE_LINE_CYC;
        b = cnt;
        for (int i = 0; i < len; i++) put(1, 10'(i), 10'(i));
        in_valid = 0;
        n = 0;
        while (cnt < b + len && n < 999) begin @(negedge mclk); n++; end
        if (n > 998) begin fail_count++; report_and_stop; end
        repeat (12) @(negedge mclk);
        `CHK(cnt - b, len)
        $display("mode %0d done", m);
    endtask
    initial begin
        for (int m = 0; m < 3; m++) run_mode(2'(m));
        report_and_stop;
    end
endmodule
`default_nettype wire
